// [cpsc_pkg.sv]
// Constants shared by the configuration pin-state controller
package cpsc_pkg;
   // Number of JTAG input pads and their places above the user pads
   localparam int unsigned NUM_JTAG = 3;
   localparam int unsigned JTAG_TDI = 0;
   localparam int unsigned JTAG_TCK = 1;
   localparam int unsigned JTAG_TMS = 2;
   // Default count of general user pads
   localparam int unsigned NUM_IO_DEF = 8;
   // Values after reset
   localparam logic PULLUP_RST = 1'h1;
   localparam logic PEND_HI_RST = 1'h1;
   localparam logic PEND_LO_RST = 1'h0;
   // Configuration phase, one-hot
   typedef enum logic [2:0] {
      ST_PRECFG = 3'h1,
      ST_CONFIG = 3'h2,
      ST_ACTIVE = 3'h4
   } cpsc_phase_t;
endpackage

// [cpsc_pad_cell.sv]
// Output and pull-up control of one pad
`timescale 1ns/1ps
`default_nettype none
module cpsc_pad_cell (
   input  wire logic clk_sys_in,
   input  wire logic resetn_in,
   input  wire logic active_in,
   input  wire logic used_in,
   input  wire logic gts_in,
   input  wire logic extest_in,
   input  wire logic user_o_in,
   input  wire logic user_oe_in,
   input  wire logic scan_o_in,
   input  wire logic scan_oe_in,
   output var  logic pad_o_out,
   output var  logic pad_oe_out,
   output var  logic pad_pu_out
);
   logic o_reg, o_next;
   logic oe_reg, oe_next;
   logic pu_reg, pu_next;

   // ****************************************
   // Pad drive selection
   // ****************************************
   always_comb begin
      o_next  = 1'h0;
      oe_next = 1'h0;
      pu_next = cpsc_pkg::PULLUP_RST;
      if (extest_in) begin
         // Scan keeps the pin even against the global 3-state
         o_next  = scan_o_in;
         oe_next = scan_oe_in;
         pu_next = 1'h0;
      end else if (active_in && used_in) begin
         o_next  = user_o_in;
         oe_next = user_oe_in && !gts_in;
         pu_next = 1'h0;
      end else begin
         // Unused or not yet configured: input with weak pull-up
         o_next  = 1'h0;
         oe_next = 1'h0;
         pu_next = 1'h1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         o_reg  <= 1'h0;
         oe_reg <= 1'h0;
         pu_reg <= cpsc_pkg::PULLUP_RST;
      end else begin
         o_reg  <= o_next;
         oe_reg <= oe_next;
         pu_reg <= pu_next;
      end
   end

   assign pad_o_out  = o_reg;
   assign pad_oe_out = oe_reg;
   assign pad_pu_out = pu_reg;
endmodule
`default_nettype wire

// [cpsc_pin_ctrl.sv]
// Pin-state control of user pads around device configuration
//
// Behaviour
// - Before and during configuration every pad not used for it floats with pull-up.
// - After configuration an unused pad is an input with pull-up, never driven.
// - There is no reset pin; any user pad can be chosen to drive the global set/reset net.
// - The global 3-state net floats all pad outputs, and the pending pins only once the I/O are active; it changes no power state.
// - There is no powerdown input; the global 3-state net is the only global float.
// - TDI, TCK and TMS go straight from their pads to scan and serve as logic inputs later.
// - Without the scan primitive scan is off once configured and JTAG pads are user pads.
// - The high pending pin is driven high until the I/O go active, then is a user pad.
// - The low pending pin is driven low until the I/O go active, then is a user pad.
// - Under EXTEST with scan enabled, scan keeps the pins despite the global 3-state net.
`timescale 1ns/1ps
`default_nettype none
module cpsc_pin_ctrl #(
   parameter int unsigned NUM_IO = cpsc_pkg::NUM_IO_DEF,
   parameter int unsigned NP     = NUM_IO + cpsc_pkg::NUM_JTAG,
   parameter int unsigned SW     = $clog2(NP)
) (
   input  wire logic          clk_sys_in,
   input  wire logic          resetn_in,
   input  wire logic          cfg_start_in,
   input  wire logic          io_active_in,
   input  wire logic          scan_inst_in,
   input  wire logic          extest_in,
   input  wire logic [NP-1:0] io_used_in,
   input  wire logic [NP-1:0] user_o_in,
   input  wire logic [NP-1:0] user_oe_in,
   input  wire logic [NP-1:0] scan_o_in,
   input  wire logic [NP-1:0] scan_oe_in,
   input  wire logic [NP-1:0] pad_i_in,
   input  wire logic          gts_pin_en_in,
   input  wire logic [SW-1:0] gts_sel_in,
   input  wire logic          gts_inv_in,
   input  wire logic          gts_int_in,
   input  wire logic          gsr_en_in,
   input  wire logic [SW-1:0] gsr_sel_in,
   input  wire logic          gsr_inv_in,
   input  wire logic [1:0]    pend_user_o_in,
   input  wire logic [1:0]    pend_user_oe_in,
   output var  logic [NP-1:0] pad_o_out,
   output var  logic [NP-1:0] pad_oe_out,
   output var  logic [NP-1:0] pad_pu_out,
   output var  logic [NP-1:0] pin_sync_out,
   output var  logic          pend_hi_o_out,
   output var  logic          pend_hi_oe_out,
   output var  logic          pend_lo_o_out,
   output var  logic          pend_lo_oe_out,
   output var  logic          gts_net_out,
   output var  logic          gsr_net_out,
   output var  logic          scan_enable_out,
   output var  logic          scan_tdi_out,
   output var  logic          scan_tck_out,
   output var  logic          scan_tms_out,
   output var  logic          io_active_out
);
   localparam int unsigned JB = NUM_IO;

   // Refuse pad counts the select fields cannot reach
   if (NUM_IO < 1 || NP != NUM_IO + cpsc_pkg::NUM_JTAG
       || SW < 1 || (1 << SW) < NP) begin : g_bad_cfg
      $error("cpsc_pin_ctrl: bad pad counts");
   end

   // ****************************************
   // Pad input synchronisers
   // ****************************************
   logic [NP-1:0] sync1_reg, sync2_reg;
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         // Idle at the pull-up level, so no false global pulse follows reset
         sync1_reg <= '1;
         sync2_reg <= '1;
      end else begin
         sync1_reg <= pad_i_in;
         sync2_reg <= sync1_reg;
      end
   end
   assign pin_sync_out = sync2_reg;

   // ****************************************
   // Configuration phase
   // ****************************************
   cpsc_pkg::cpsc_phase_t state_reg, state_next;
   logic active;
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cpsc_pkg::ST_PRECFG: begin
            if (cfg_start_in) begin
               state_next = cpsc_pkg::ST_CONFIG;
            end
         end
         cpsc_pkg::ST_CONFIG: begin
            if (io_active_in) begin
               state_next = cpsc_pkg::ST_ACTIVE;
            end
         end
         cpsc_pkg::ST_ACTIVE: begin
            // Only reconfiguration leaves; 3-state never does
            if (cfg_start_in) begin
               state_next = cpsc_pkg::ST_CONFIG;
            end
         end
         default: state_next = cpsc_pkg::ST_PRECFG;
      endcase
   end
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         state_reg <= cpsc_pkg::ST_PRECFG;
      end else begin
         state_reg <= state_next;
      end
   end
   assign active        = (state_reg == cpsc_pkg::ST_ACTIVE);
   assign io_active_out = active;

   // ****************************************
   // Global nets and scan routing
   // ****************************************
   logic global_tristate_net, gsr_src, gsr_next, gsr_reg, scan_en, extest;
   // No dedicated reset pin: any synchronised pad may feed set/reset
   assign gsr_src  = sync2_reg[gsr_sel_in] ^ gsr_inv_in;
   assign gsr_next = gsr_en_in && gsr_src;
   assign global_tristate_net      = gts_int_in || (gts_pin_en_in && (sync2_reg[gts_sel_in] ^ gts_inv_in));
   // Scan lives through configuration, then only if instantiated
   assign scan_en  = !active || scan_inst_in;
   assign extest   = scan_en && extest_in;
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         gsr_reg <= 1'h0;
      end else begin
         gsr_reg <= gsr_next;
      end
   end
   assign gsr_net_out     = gsr_reg;
   assign gts_net_out     = global_tristate_net;
   assign scan_enable_out = scan_en;
   // Direct from pad, no io_cell in the path
   assign scan_tdi_out    = scan_en && sync2_reg[JB + cpsc_pkg::JTAG_TDI];
   assign scan_tck_out    = scan_en && sync2_reg[JB + cpsc_pkg::JTAG_TCK];
   assign scan_tms_out    = scan_en && sync2_reg[JB + cpsc_pkg::JTAG_TMS];

   // ****************************************
   // Pad cells
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_pad
         logic used;
         // JTAG pads drive only once scan is gone
         if (gi >= JB) begin : g_jtag
            assign used = io_used_in[gi] && !scan_en;
         end else begin : g_user
            assign used = io_used_in[gi];
         end
         cpsc_pad_cell u_cell (
            .clk_sys_in (clk_sys_in),
            .resetn_in  (resetn_in),
            .active_in  (active),
            .used_in    (used),
            .gts_in     (global_tristate_net),
            .extest_in  (extest),
            .user_o_in  (user_o_in[gi]),
            .user_oe_in (user_oe_in[gi]),
            .scan_o_in  (scan_o_in[gi]),
            .scan_oe_in (scan_oe_in[gi]),
            .pad_o_out  (pad_o_out[gi]),
            .pad_oe_out (pad_oe_out[gi]),
            .pad_pu_out (pad_pu_out[gi])
         );
      end
   endgenerate

   // ****************************************
   // Pending status pins
   // ****************************************
   logic hi_o_reg, hi_o_next, hi_oe_reg, hi_oe_next;
   logic lo_o_reg, lo_o_next, lo_oe_reg, lo_oe_next;
   always_comb begin
      // One phase decode feeds both, so they switch together
      if (!active) begin
         hi_o_next  = 1'h1;
         hi_oe_next = 1'h1;
         lo_o_next  = 1'h0;
         lo_oe_next = 1'h1;
      end else begin
         hi_o_next  = pend_user_o_in[0];
         hi_oe_next = pend_user_oe_in[0] && !global_tristate_net;
         lo_o_next  = pend_user_o_in[1];
         lo_oe_next = pend_user_oe_in[1] && !global_tristate_net;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         hi_o_reg  <= cpsc_pkg::PEND_HI_RST;
         hi_oe_reg <= 1'h1;
         lo_o_reg  <= cpsc_pkg::PEND_LO_RST;
         lo_oe_reg <= 1'h1;
      end else begin
         hi_o_reg  <= hi_o_next;
         hi_oe_reg <= hi_oe_next;
         lo_o_reg  <= lo_o_next;
         lo_oe_reg <= lo_oe_next;
      end
   end
   assign pend_hi_o_out  = hi_o_reg;
   assign pend_hi_oe_out = hi_oe_reg;
   assign pend_lo_o_out  = lo_o_reg;
   assign pend_lo_oe_out = lo_oe_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);

   precfg_float_a: assert property (
         !active && !extest |=> pad_oe_out == '0 && pad_pu_out == '1)
      else $error("pad driven before I/O active");
   unused_input_a: assert property (
         active && !extest |=> (pad_oe_out & ~$past(io_used_in)) == '0)
      else $error("unused pad driven");
   gsr_source_a: assert property (
         ##1 gsr_net_out == ($past(gsr_en_in) && $past(gsr_src)))
      else $error("set/reset net not from chosen pad");
   gts_float_a: assert property (global_tristate_net && !extest |=> pad_oe_out == '0)
      else $error("output driven under global 3-state");
   gts_keep_a: assert property (active && global_tristate_net && !cfg_start_in |=> active)
      else $error("global 3-state changed phase");
   extest_hold_a: assert property (
         extest |=> pad_oe_out == $past(scan_oe_in) && pad_o_out == $past(scan_o_in))
      else $error("scan lost pins under extest");
   jtag_route_a: assert property (
         scan_en |-> scan_tdi_out == pin_sync_out[JB + cpsc_pkg::JTAG_TDI]
            && scan_tck_out == pin_sync_out[JB + cpsc_pkg::JTAG_TCK]
            && scan_tms_out == pin_sync_out[JB + cpsc_pkg::JTAG_TMS]
            && pin_sync_out == sync2_reg)
      else $error("jtag input not routed");
   scan_off_a: assert property (
         active && !scan_inst_in |-> !scan_enable_out && !scan_tms_out)
      else $error("scan alive without primitive");
   pend_high_a: assert property (!active |=> pend_hi_o_out && pend_hi_oe_out)
      else $error("high pending pin not high");
   pend_low_a: assert property (!active |=> !pend_lo_o_out && pend_lo_oe_out)
      else $error("low pending pin not low");
   pend_comp_a: assert property (!$past(active) |-> pend_hi_o_out != pend_lo_o_out)
      else $error("pending pins not complementary");

   cfg_done_c: cover property (state_reg == cpsc_pkg::ST_CONFIG ##1 active);
   gts_hit_c:  cover property (active && global_tristate_net && |user_oe_in);
   extest_c:   cover property (active && extest && global_tristate_net);
   reconf_c:   cover property (active ##1 state_reg == cpsc_pkg::ST_CONFIG);
endmodule
`default_nettype wire

// [cpsc_board_model.sv]
// Board-side model of the pad wires and the configuration status pins
`timescale 1ns/1ps
`default_nettype none
module cpsc_board_model #(
   parameter int unsigned NP = 11
) (
   input  wire logic          clk_sys_in,
   input  wire logic [NP-1:0] pad_o_in,
   input  wire logic [NP-1:0] pad_oe_in,
   input  wire logic [NP-1:0] pad_pu_in,
   input  wire logic [NP-1:0] ext_o_in,
   input  wire logic [NP-1:0] ext_oe_in,
   input  wire logic [1:0]    pend_o_in,
   input  wire logic [1:0]    pend_oe_in,
   output var  logic [NP-1:0] pad_wire_out,
   output var  logic          pend_seen_out
);
   logic [NP-1:0] last_reg = '0;
   logic [1:0]    pend_last_reg = '0;
   logic [1:0]    pend_w;
   // Undriven lines without pull-up invert, so a stale level never passes
   always_comb begin
      for (int i = 0; i < NP; i++) begin
         if (pad_oe_in[i]) pad_wire_out[i] = pad_o_in[i];
         else if (ext_oe_in[i]) pad_wire_out[i] = ext_o_in[i];
         else if (pad_pu_in[i]) pad_wire_out[i] = 1'b1;
         else pad_wire_out[i] = ~last_reg[i];
      end
      for (int j = 0; j < 2; j++) begin
         pend_w[j] = pend_oe_in[j] ? pend_o_in[j] : ~pend_last_reg[j];
      end
      pend_seen_out = pend_w[0] & ~pend_w[1];
   end
   always_ff @(posedge clk_sys_in) begin
      last_reg      <= pad_wire_out;
      pend_last_reg <= pend_w;
   end
endmodule
`default_nettype wire

// [cpsc_pin_ctrl_tb.sv]
// Self-checking bench for the configuration pin-state controller
`timescale 1ns/1ps
`default_nettype none
module cpsc_pin_ctrl_tb;
   typedef struct packed {
      logic [2:0]  ins;
      logic [10:0] oe;
      logic [10:0] o;
      logic        tck;
   } cpsc_row_t;
   logic        clk_sys_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        cfg_start = 1'b0, io_act = 1'b0, scan_inst = 1'b0, extest = 1'b0;
   logic        gts_int = 1'b0, gts_en = 1'b0, gts_inv = 1'b0, gsr_en = 1'b0, gsr_inv = 1'b0;
   logic [3:0]  gts_sel = 4'h1, gsr_sel = 4'h3;
   logic [10:0] used = 11'h2F5, u_o = 11'h5A3, u_oe = 11'h7FF, s_o = 11'h3CC, s_oe = 11'h0F0;
   logic [10:0] ext_o = 11'h7FF, ext_oe = 11'h20A, pad_w, p_o, p_oe, p_pu, sync;
   logic [1:0]  pu_o = 2'h2, pu_oe = 2'h3;
   logic        hi_o, hi_oe, lo_o, lo_oe, gts_net, gsr_net, scan_en, tdi, tck, tms;
   logic        active, seen;
   int          n_errors = 0;
   int          checks_done = 0;
   cpsc_row_t   rows [8];

   always #2 clk_sys_in = ~clk_sys_in;

   cpsc_pin_ctrl #(.NUM_IO(8)) dut (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cfg_start_in(cfg_start),
      .io_active_in(io_act), .scan_inst_in(scan_inst), .extest_in(extest),
      .io_used_in(used), .user_o_in(u_o), .user_oe_in(u_oe),
      .scan_o_in(s_o), .scan_oe_in(s_oe), .pad_i_in(pad_w),
      .gts_pin_en_in(gts_en), .gts_sel_in(gts_sel), .gts_inv_in(gts_inv),
      .gts_int_in(gts_int), .gsr_en_in(gsr_en), .gsr_sel_in(gsr_sel),
      .gsr_inv_in(gsr_inv), .pend_user_o_in(pu_o), .pend_user_oe_in(pu_oe),
      .pad_o_out(p_o), .pad_oe_out(p_oe), .pad_pu_out(p_pu), .pin_sync_out(sync),
      .pend_hi_o_out(hi_o), .pend_hi_oe_out(hi_oe), .pend_lo_o_out(lo_o),
      .pend_lo_oe_out(lo_oe), .gts_net_out(gts_net), .gsr_net_out(gsr_net),
      .scan_enable_out(scan_en), .scan_tdi_out(tdi), .scan_tck_out(tck),
      .scan_tms_out(tms), .io_active_out(active)
   );

   cpsc_board_model #(.NP(11)) board (
      .clk_sys_in(clk_sys_in), .pad_o_in(p_o), .pad_oe_in(p_oe), .pad_pu_in(p_pu),
      .ext_o_in(ext_o), .ext_oe_in(ext_oe), .pend_o_in({lo_o, hi_o}),
      .pend_oe_in({lo_oe, hi_oe}), .pad_wire_out(pad_w), .pend_seen_out(seen)
   );

   task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic conclude();
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      // Rows: {gts, extest, scan present}, pad enables, driven values, scan clock
      rows[0] = {3'h0, 11'h2F5, 11'h0A1, 1'b0};
      rows[1] = {3'h1, 11'h0F5, 11'h0A1, 1'b1};
      rows[2] = {3'h2, 11'h2F5, 11'h0A1, 1'b0};
      rows[3] = {3'h3, 11'h0F0, 11'h0C0, 1'b1};
      rows[4] = {3'h4, 11'h000, 11'h000, 1'b0};
      rows[5] = {3'h5, 11'h000, 11'h000, 1'b1};
      rows[6] = {3'h6, 11'h000, 11'h000, 1'b0};
      rows[7] = {3'h7, 11'h0F0, 11'h0C0, 1'b1};
      step(8);
      resetn_in = 1'b1;
      chk("pad_oe", p_oe, 11'h000);
      chk("pad_pu", p_pu, 11'h7FF);
      chk("pend", {hi_oe, hi_o, lo_oe, lo_o}, 11'hE);
      io_act = 1'b1;
      step(1);
      io_act = 1'b0;
      step(2);
      chk("active", active, 1'b0);
      cfg_start = 1'b1;
      step(1);
      cfg_start = 1'b0;
      step(3);
      chk("pad_oe", p_oe, 11'h000);
      chk("pad_pu", p_pu, 11'h7FF);
      chk("seen", seen, 1'b1);
      io_act = 1'b1;
      step(1);
      io_act = 1'b0;
      chk("active", active, 1'b1);
      chk("pend", {hi_oe, hi_o, lo_oe, lo_o}, 11'hE);
      step(1);
      chk("pend", {hi_oe, hi_o, lo_oe, lo_o}, 11'hB);
      for (int r = 0; r < 8; r++) begin
         {gts_int, extest, scan_inst} = rows[r].ins;
         step(4);
         chk("pad_oe", p_oe, rows[r].oe);
         chk("pad_o", p_o & p_oe, rows[r].o);
         chk("scan_tck", tck, rows[r].tck);
         chk("scan_en", scan_en, rows[r].ins[0]);
         chk("pend_oe", {hi_oe, lo_oe}, rows[r].ins[2] ? 11'h0 : 11'h3);
         if (!(rows[r].ins[1] && rows[r].ins[0])) begin
            chk("pad_pu", p_pu & 11'h50A, 11'h50A);
            chk("scan_tdi", tdi, rows[r].ins[0]);
            chk("scan_tms", tms, rows[r].ins[0]);
         end
      end
      {gts_int, extest, scan_inst} = 3'h0;
      // Global nets sourced from unused user pads
      ext_o[3] = 1'b0;
      gsr_en = 1'b1;
      step(4);
      chk("gsr", gsr_net, 1'b0);
      ext_o[3] = 1'b1;
      step(4);
      chk("gsr", gsr_net, 1'b1);
      gsr_inv = 1'b1;
      step(2);
      chk("gsr", gsr_net, 1'b0);
      gts_en = 1'b1;
      step(4);
      chk("gts", gts_net, 1'b1);
      chk("pad_oe", p_oe, 11'h000);
      chk("active", active, 1'b1);
      gts_inv = 1'b1;
      step(3);
      chk("gts", gts_net, 1'b0);
      chk("pad_oe", p_oe, 11'h2F5);
      chk("pin_sync", sync, 11'h5AB);
      // Reconfiguration from the active phase
      cfg_start = 1'b1;
      step(1);
      cfg_start = 1'b0;
      chk("active", active, 1'b0);
      step(1);
      chk("pend", {hi_oe, hi_o, lo_oe, lo_o}, 11'hE);
      chk("pad_oe", p_oe, 11'h000);
      chk("seen", seen, 1'b1);
      // Mid-run reset from the active phase
      io_act = 1'b1;
      step(3);
      io_act = 1'b0;
      chk("pad_oe", p_oe, 11'h2F5);
      resetn_in = 1'b0;
      step(2);
      resetn_in = 1'b1;
      chk("pad_oe", p_oe, 11'h000);
      chk("pend", {hi_oe, hi_o, lo_oe, lo_o}, 11'hE);
      chk("gts", gts_net, 1'b0);
      step(1);
      chk("active", active, 1'b0);
      chk("gsr", gsr_net, 1'b0);
      conclude();
   end

   // Generous bound: the sequence needs well under 200 cycles
   initial begin
      #20000;
      n_errors++;
      conclude();
   end
endmodule
`default_nettype wire
